// ===== bench/ahb_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host model: single word transfers on ahb-lite
// ----------------------------------------------------------------
module ahb_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // bus idle from time zero
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
  end

  // one transfer; byte address is four times the word index
  task automatic xfer(input logic [13:0] idx, input logic wr, input logic [7:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {16'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    // address phase held until the slave is ready
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    haddr <= ~haddr;
    hwdata <= {24'h0, d};
    // data phase held until the slave is ready
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~hwdata;
  endtask
endmodule

// ===== bench/test_prog_fir_coef_loader.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bench for the coefficient loader
// ----------------------------------------------------------------
module test_prog_fir_coef_loader;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [2:0] gpio;
  logic [2:0] mode_i;
  logic [2:0] mode_q;
  logic [7:0] gain_i;
  logic [7:0] gain_q;
  logic [5:0] tap_delay_i;
  logic [383:0] ix;
  logic [383:0] iy;
  logic [383:0] qx;
  logic [383:0] qy;
  logic pulse;
  logic fault;
  logic [31:0] q;
  logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int pulses = 0;

  prog_fir_coef_loader #(.NUM_GPIO(3)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .gpio_in(gpio), .mode_i(mode_i), .mode_q(mode_q), .gain_i(gain_i),
    .gain_q(gain_q), .tap_delay_i(tap_delay_i), .inphase_x_coef_set(ix), .inphase_y_coef_set(iy),
    .quadrature_x_coef_set(qx), .quadrature_y_coef_set(qy), .coef_apply_pulse(pulse), .mode_pair_fault(fault));

  ahb_host h (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // 25 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // apply pulse counter and hang limit
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (pulse === 1'b1)
      pulses <= pulses + 1;
    if (cyc == 5000)
    begin
      errors++;
      end_sim;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // compare and report
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      errors++;
    end
  endtask

  task automatic wr(input logic [13:0] i, input logic [7:0] d);
    h.xfer(i, 1'b1, d, q);
  endtask

  task automatic rd(input string n, input logic [13:0] i, input logic [7:0] e);
    h.xfer(i, 1'b0, 8'h00, q);
    chk(n, {24'h0, e}, q);
  endtask

  // let registered outputs land
  task automatic settle;
    repeat (3) @(posedge hclk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    gpio = 3'b000;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd("mode_nopath", fir_coef_pkg::IDX_MODE, 8'h00);
    wr(fir_coef_pkg::IDX_PATH_SEL, fir_coef_pkg::SEL_PATH_A);
    wr(fir_coef_pkg::IDX_MODE, 8'hff);
    rd("mode_a", fir_coef_pkg::IDX_MODE, 8'h07);
    wr(fir_coef_pkg::IDX_GAIN, 8'hff);
    rd("gain_a", fir_coef_pkg::IDX_GAIN, 8'h77);
    wr(fir_coef_pkg::IDX_PATH_SEL, fir_coef_pkg::SEL_PATH_B);
    wr(fir_coef_pkg::IDX_GAIN, 8'h26);
    settle;
    chk("gain_q", 32'h26, {24'h0, gain_q});
    chk("gain_i", 32'h77, {24'h0, gain_i});
    chk("mode_i", 32'h7, {29'h0, mode_i});
    // every mode code lands on the quadrature path
    foreach (codes[k])
    begin
      wr(fir_coef_pkg::IDX_MODE, {5'h00, codes[k]});
      settle;
      chk("mode_q", {29'h0, codes[k]}, {29'h0, mode_q});
    end
    // opposite path pairing
    wr(fir_coef_pkg::IDX_PATH_SEL, fir_coef_pkg::SEL_PATH_A);
    wr(fir_coef_pkg::IDX_MODE, 8'h00);
    settle;
    chk("fault_96", 32'h0, {31'h0, fault});
    wr(fir_coef_pkg::IDX_MODE, 8'h06);
    settle;
    chk("fault_half", 32'h1, {31'h0, fault});
    wr(fir_coef_pkg::IDX_PATH_SEL, fir_coef_pkg::SEL_PATH_B);
    wr(fir_coef_pkg::IDX_MODE, 8'h02);
    settle;
    chk("fault_ok", 32'h0, {31'h0, fault});
    wr(fir_coef_pkg::IDX_MODE, 8'h05);
    wr(fir_coef_pkg::IDX_PATH_SEL, fir_coef_pkg::SEL_PATH_A);
    wr(fir_coef_pkg::IDX_MODE, 8'h05);
    settle;
    chk("fault_full", 32'h0, {31'h0, fault});
    repeat (fir_coef_pkg::PWRUP_CYC + 5) @(posedge hclk);
    // in-phase shadows, then quadrature shadows in the same windows
    wr(fir_coef_pkg::IDX_X_LO, 8'h34);
    wr(fir_coef_pkg::IDX_X_LO + 14'h1, 8'h82);
    wr(fir_coef_pkg::IDX_X_HI, 8'h7f);
    wr(fir_coef_pkg::IDX_Y_LO, 8'h11);
    wr(fir_coef_pkg::IDX_DELAY, 8'd50);
    wr(fir_coef_pkg::IDX_PATH_SEL, fir_coef_pkg::SEL_PATH_B);
    wr(fir_coef_pkg::IDX_X_LO, 8'h78);
    wr(fir_coef_pkg::IDX_X_LO + 14'h1, 8'h56);
    wr(fir_coef_pkg::IDX_Y_LO, 8'h5a);
    rd("shadow", fir_coef_pkg::IDX_X_LO, 8'h78);
    wr(fir_coef_pkg::IDX_XFER, 8'h02);
    settle;
    chk("held", 32'h0, {16'h0, ix[15:0]});
    chk("pulse_lvl", 32'h0, {31'h0, pulse});
    chk("no_pulse", 32'h0, pulses);
    wr(fir_coef_pkg::IDX_XFER, fir_coef_pkg::XFER_CMD);
    settle;
    chk("ix0", 32'h8234, {16'h0, ix[15:0]});
    chk("ix23", 32'h7f00, {16'h0, ix[383:368]});
    chk("iy0", 32'h0011, {16'h0, iy[15:0]});
    chk("qx0", 32'h5678, {16'h0, qx[15:0]});
    chk("qy0", 32'h005a, {16'h0, qy[15:0]});
    chk("delay", 32'h2f, {26'h0, tap_delay_i});
    chk("pulse", 32'h1, pulses);
    // gpio transfer: unassigned pin first, then assigned pin
    wr(fir_coef_pkg::IDX_X_LO, 8'h9a);
    gpio <= 3'b001;
    settle;
    chk("qx_pin0", 32'h5678, {16'h0, qx[15:0]});
    wr(fir_coef_pkg::IDX_GPIO_LO + 14'h1, {4'h0, fir_coef_pkg::GPIO_FN_XFER});
    gpio <= 3'b011;
    settle;
    settle;
    chk("qx_pin1", 32'h569a, {16'h0, qx[15:0]});
    chk("pulse2", 32'h2, pulses);
    rd("status", fir_coef_pkg::IDX_STATUS, 8'h08);
    rd("unmapped", 14'h1000, 8'h00);
    chk("hresp", 32'h0, {31'h0, hresp});
    end_sim;
  end
endmodule

// ===== include/fir_coef_pkg.sv
package fir_coef_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_PATH_SEL = 14'h0008; // path select index
  localparam logic [13:0] IDX_XFER = 14'h000f; // coefficient apply strobe
  localparam logic [13:0] IDX_STATUS = 14'h0010; // block status
  localparam logic [13:0] IDX_GPIO_LO = 14'h0040; // first gpio config
  localparam logic [13:0] IDX_MODE = 14'h0df8; // filter mode select
  localparam logic [13:0] IDX_GAIN = 14'h0df9; // filter gain select
  localparam logic [13:0] IDX_X_LO = 14'h0e00; // x coefficient window start
  localparam logic [13:0] IDX_X_HI = 14'h0e2f; // x coefficient window end
  localparam logic [13:0] IDX_Y_LO = 14'h0f00; // y coefficient window start
  localparam logic [13:0] IDX_Y_HI = 14'h0f2f; // y coefficient window end
  localparam logic [13:0] IDX_DELAY = 14'h0f30; // tapped delay setting
  localparam logic [13:0] IDX_NONE = 14'h3fff; // marks an unmapped access

  // ----------------------------------------------------------------
  // field values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SEL_PATH_A = 8'h01; // in-phase path
  localparam logic [7:0] SEL_PATH_B = 8'h02; // quadrature path
  localparam logic [7:0] XFER_CMD = 8'h01; // apply shadow coefficients
  localparam logic [7:0] MODE_FIELD = 8'h07; // mode bits [2:0]
  localparam logic [7:0] GAIN_FIELD = 8'h77; // gain bits [6:4] and [2:0]
  localparam logic [3:0] GPIO_FN_XFER = 4'h1; // gpio function code: transfer
  localparam logic [5:0] DELAY_MAX = 6'h2f; // deepest tapped delay
  localparam logic [7:0] REG_RESET = 8'h00; // reset of every register
  localparam int COEF_TAPS = 24; // coefficients per window
  localparam int COEF_BYTES = 48; // bytes per window

  // ----------------------------------------------------------------
  // filter mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_BYPASS = 3'h0; // filters bypassed
  localparam logic [2:0] MODE_X24 = 3'h1; // real 24 taps, x only
  localparam logic [2:0] MODE_XY48 = 3'h2; // real 48 taps, x and y joined
  localparam logic [2:0] MODE_CASC = 3'h4; // x then y cascaded
  localparam logic [2:0] MODE_FULLCPX = 3'h5; // full complex, four 24-tap
  localparam logic [2:0] MODE_HALFCPX = 3'h6; // half complex, 48 taps + delay
  localparam logic [2:0] MODE_R96 = 3'h7; // real 96 taps, all four sets

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 40000; // 25 MHz sample clock
  localparam int PWRUP_TIME_US = 5; // filter power-up, in microseconds
  localparam int PWRUP_CYC = (PWRUP_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// ===== src/prog_fir_coef_loader.sv
// Function
// RULE_01 - host starts sample clock before programming
// RULE_02 - index 0x01 selects in-phase path
// RULE_03 - index 0x02 selects quadrature path
// RULE_04 - mode bits [2:0]; 000 bypass, 001 x24
// RULE_05 - mode 010 joins x and y
// RULE_06 - mode 100 cascades x then y
// RULE_07 - full complex 101 on both paths
// RULE_08 - half complex 110 needs opposite 010
// RULE_09 - real 96 tap 111 needs opposite 000
// RULE_10 - gain fields y [6:4], x [2:0]
// RULE_11 - wait 5 us after mode setup
// RULE_12 - x coefficients, low byte even offset
// RULE_13 - y coefficients in second window
// RULE_14 - quadrature set uses same windows
// RULE_15 - tapped delay write is optional
// RULE_16 - coefficients apply only on transfer
// RULE_17 - writing 0x01 triggers transfer
// RULE_18 - gpio config can assign transfer function
// RULE_19 - rising gpio edge starts transfer
// RULE_20 - mode change demands full coefficient reload
// RULE_21 - coefficients are signed Q1.15
// RULE_22 - tapped delay 0 to 47 taps
// RULE_23 - running filter ignores shadow writes
`timescale 1ns/1ps
module prog_fir_coef_loader #(
  parameter int NUM_GPIO = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NUM_GPIO-1:0] gpio_in,
  output logic [2:0] mode_i,
  output logic [2:0] mode_q,
  output logic [7:0] gain_i,
  output logic [7:0] gain_q,
  output logic [5:0] tap_delay_i,
  output logic [16*fir_coef_pkg::COEF_TAPS-1:0] inphase_x_coef_set,
  output logic [16*fir_coef_pkg::COEF_TAPS-1:0] inphase_y_coef_set,
  output logic [16*fir_coef_pkg::COEF_TAPS-1:0] quadrature_x_coef_set,
  output logic [16*fir_coef_pkg::COEF_TAPS-1:0] quadrature_y_coef_set,
  output logic coef_apply_pulse,
  output logic mode_pair_fault
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic acc_ok; // accepted address phase
  logic wr_pend_reg; // write data phase in progress
  logic rd_pend_reg; // read wait cycle in progress
  logic [13:0] idx_reg; // captured register index
  logic hreadyout_reg; // bus ready
  logic [31:0] hrdata_reg; // registered read data
  logic [7:0] rd_val; // read mux result
  logic [7:0] wdat; // write byte
  logic sel_ok; // index names a path
  logic sel_p; // 0 in-phase, 1 quadrature
  logic in_x; // index in x window
  logic in_y; // index in y window
  logic [5:0] x_off; // byte offset in x window
  logic [5:0] y_off; // byte offset in y window
  logic wr_mode; // write to mode register
  logic [7:0] path_sel_reg; // path select index
  logic [7:0] mode_reg [0:1]; // per path mode
  logic [7:0] gain_reg [0:1]; // per path gain
  logic [7:0] shx_reg [0:1][0:fir_coef_pkg::COEF_BYTES-1]; // x shadow bytes
  logic [7:0] shy_reg [0:1][0:fir_coef_pkg::COEF_BYTES-1]; // y shadow bytes
  logic [15:0] actx_reg [0:1][0:fir_coef_pkg::COEF_TAPS-1]; // applied x taps
  logic [15:0] acty_reg [0:1][0:fir_coef_pkg::COEF_TAPS-1]; // applied y taps
  logic [5:0] dly_sh_reg; // shadow tapped delay
  logic [5:0] dly_act_reg; // applied tapped delay
  logic [7:0] gpio_cfg_reg [0:NUM_GPIO-1]; // gpio function per pin
  logic [NUM_GPIO-1:0] gmeta_reg; // first sync stage
  logic [NUM_GPIO-1:0] gsync_reg; // second sync stage
  logic [NUM_GPIO-1:0] gprev_reg; // previous synced level
  logic gpio_hit; // configured pin rose
  logic xfer_go; // apply shadow now
  logic coef_apply_reg; // transfer pulse out
  logic [7:0] xfer_cnt_reg; // transfers since reset
  logic [7:0] pwr_cnt_reg; // power-up countdown
  logic pair_fault; // illegal mode pairing
  logic pair_fault_reg; // registered pairing fault

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  assign acc_ok = hsel && htrans[1] && hready;

  // capture the address phase; reads get one wait cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      idx_reg <= fir_coef_pkg::IDX_NONE;
      hreadyout_reg <= 1'b1;
    end
    else
    begin
      wr_pend_reg <= acc_ok && hwrite;
      rd_pend_reg <= acc_ok && !hwrite;
      hreadyout_reg <= !(acc_ok && !hwrite);
      if (acc_ok)
      begin
        // word sized and aligned, low 64 kB only; everything else is unmapped
        if (haddr[31:16] == 16'h0000 && haddr[1:0] == 2'b00 && hsize == 3'b010)
          idx_reg <= haddr[15:2];
        else
          idx_reg <= fir_coef_pkg::IDX_NONE;
      end
    end
  end

  // read data is loaded in the wait cycle, after any earlier write landed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_reg <= 32'h0000_0000;
    else if (rd_pend_reg)
      hrdata_reg <= {24'h00_0000, rd_val};
    else
      hrdata_reg <= 32'h0000_0000;
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0;

  // a read data phase: one wait cycle, then ready again
  sequence read_wait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  read_wait_a: assert property (acc_ok && !hwrite |=> read_wait_s)
    else $error("read did not take exactly one wait cycle");

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign wdat = hwdata[7:0];
  assign sel_ok = (path_sel_reg == fir_coef_pkg::SEL_PATH_A) || (path_sel_reg == fir_coef_pkg::SEL_PATH_B); // RULE_02
  assign sel_p = (path_sel_reg == fir_coef_pkg::SEL_PATH_B); // RULE_03
  assign in_x = idx_reg >= fir_coef_pkg::IDX_X_LO && idx_reg <= fir_coef_pkg::IDX_X_HI; // RULE_12
  assign in_y = idx_reg >= fir_coef_pkg::IDX_Y_LO && idx_reg <= fir_coef_pkg::IDX_Y_HI; // RULE_13
  assign x_off = 6'(idx_reg - fir_coef_pkg::IDX_X_LO);
  assign y_off = 6'(idx_reg - fir_coef_pkg::IDX_Y_LO);
  assign wr_mode = wr_pend_reg && sel_ok && idx_reg == fir_coef_pkg::IDX_MODE;

  // read mux; per-path registers follow the path select index
  always_comb
  begin
    rd_val = 8'h00;
    if (idx_reg == fir_coef_pkg::IDX_PATH_SEL)
      rd_val = path_sel_reg;
    else if (idx_reg == fir_coef_pkg::IDX_STATUS)
      rd_val = {xfer_cnt_reg[5:0], pair_fault_reg, pwr_cnt_reg != 8'h00};
    else if (idx_reg >= fir_coef_pkg::IDX_GPIO_LO && idx_reg < fir_coef_pkg::IDX_GPIO_LO + 14'(NUM_GPIO))
      rd_val = gpio_cfg_reg[idx_reg[1:0]];
    else if (sel_ok)
    begin
      // unselected index reads the path registers as zero
      if (idx_reg == fir_coef_pkg::IDX_MODE)
        rd_val = mode_reg[sel_p]; // RULE_04
      else if (idx_reg == fir_coef_pkg::IDX_GAIN)
        rd_val = gain_reg[sel_p]; // RULE_10
      else if (in_x)
        rd_val = shx_reg[sel_p][x_off]; // RULE_14
      else if (in_y)
        rd_val = shy_reg[sel_p][y_off];
      else if (idx_reg == fir_coef_pkg::IDX_DELAY && !sel_p)
        rd_val = {2'b00, dly_sh_reg};
    end
  end

  // ----------------------------------------------------------------
  // path select, mode and gain
  // ----------------------------------------------------------------
  // index register; modes and gains act at once, no shadowing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      path_sel_reg <= fir_coef_pkg::REG_RESET;
      for (int p = 0; p < 2; p++)
      begin
        mode_reg[p] <= fir_coef_pkg::REG_RESET;
        gain_reg[p] <= fir_coef_pkg::REG_RESET;
      end
    end
    else if (wr_pend_reg)
    begin
      if (idx_reg == fir_coef_pkg::IDX_PATH_SEL)
        path_sel_reg <= wdat; // RULE_02 RULE_03
      else if (wr_mode)
        mode_reg[sel_p] <= wdat & fir_coef_pkg::MODE_FIELD; // RULE_04 RULE_05 RULE_06
      else if (sel_ok && idx_reg == fir_coef_pkg::IDX_GAIN)
        gain_reg[sel_p] <= wdat & fir_coef_pkg::GAIN_FIELD; // RULE_10
    end
  end

  assign mode_i = mode_reg[0][2:0];
  assign mode_q = mode_reg[1][2:0];
  assign gain_i = gain_reg[0];
  assign gain_q = gain_reg[1];

  mode_a_write_a: assert property (wr_mode && !sel_p |=> mode_i == $past(hwdata[2:0])) // RULE_02
    else $error("in-phase mode not written");
  mode_b_write_a: assert property (wr_mode && sel_p |=> mode_q == $past(hwdata[2:0]) && $stable(mode_i)) // RULE_03
    else $error("quadrature mode not written or in-phase disturbed");
  mode_reserved_a: assert property (rd_pend_reg && idx_reg == fir_coef_pkg::IDX_MODE |=> hrdata[7:3] == 5'h00) // RULE_04
    else $error("mode reserved bits read nonzero");
  gain_fields_a: assert property ( // RULE_10
    wr_pend_reg && sel_ok && idx_reg == fir_coef_pkg::IDX_GAIN
    |=> gain_reg[$past(sel_p)] == ($past(hwdata[7:0]) & 8'h77))
    else $error("gain fields not stored");

  // opposite-path pairings that complex and 96-tap modes rely on
  always_comb
  begin
    pair_fault = 1'b0;
    if ((mode_i == fir_coef_pkg::MODE_FULLCPX) != (mode_q == fir_coef_pkg::MODE_FULLCPX))
      pair_fault = 1'b1; // RULE_07
    if (mode_i == fir_coef_pkg::MODE_HALFCPX && mode_q != fir_coef_pkg::MODE_XY48)
      pair_fault = 1'b1; // RULE_08
    if (mode_q == fir_coef_pkg::MODE_HALFCPX && mode_i != fir_coef_pkg::MODE_XY48)
      pair_fault = 1'b1; // RULE_08
    if (mode_i == fir_coef_pkg::MODE_R96 && mode_q != fir_coef_pkg::MODE_BYPASS)
      pair_fault = 1'b1; // RULE_09
    if (mode_q == fir_coef_pkg::MODE_R96 && mode_i != fir_coef_pkg::MODE_BYPASS)
      pair_fault = 1'b1; // RULE_09
  end

  // filter power-up countdown after each mode write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pwr_cnt_reg <= 8'h00;
      pair_fault_reg <= 1'b0;
    end
    else
    begin
      pair_fault_reg <= pair_fault;
      if (wr_mode)
        pwr_cnt_reg <= 8'(fir_coef_pkg::PWRUP_CYC); // RULE_11 RULE_20
      else if (pwr_cnt_reg != 8'h00)
        pwr_cnt_reg <= pwr_cnt_reg - 8'h01;
    end
  end

  assign mode_pair_fault = pair_fault_reg;

  pwrup_load_a: assert property (wr_mode |=> pwr_cnt_reg == 8'd125) // RULE_11
    else $error("power-up count not loaded with 125 cycles");
  pair_96_a: assert property (mode_i == 3'h7 && mode_q != 3'h0 |=> mode_pair_fault) // RULE_09
    else $error("96-tap pairing fault missed");

  // ----------------------------------------------------------------
  // shadow coefficient storage
  // ----------------------------------------------------------------
  // byte writes into the selected path's shadow windows
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int p = 0; p < 2; p++)
        for (int b = 0; b < fir_coef_pkg::COEF_BYTES; b++)
        begin
          shx_reg[p][b] <= fir_coef_pkg::REG_RESET;
          shy_reg[p][b] <= fir_coef_pkg::REG_RESET;
        end
      dly_sh_reg <= 6'h00;
    end
    else if (wr_pend_reg && sel_ok)
    begin
      if (in_x)
        shx_reg[sel_p][x_off] <= wdat; // RULE_12 RULE_14
      else if (in_y)
        shy_reg[sel_p][y_off] <= wdat; // RULE_13 RULE_14
      else if (idx_reg == fir_coef_pkg::IDX_DELAY && !sel_p)
        // deeper settings clamp to the last tap
        dly_sh_reg <= (wdat > 8'(fir_coef_pkg::DELAY_MAX)) ? fir_coef_pkg::DELAY_MAX : wdat[5:0]; // RULE_15 RULE_22
    end
  end

  x_byte_a: assert property (wr_pend_reg && sel_ok && in_x |=> shx_reg[$past(sel_p)][$past(x_off)] == $past(wdat)) // RULE_12
    else $error("x shadow byte not stored");
  y_byte_a: assert property (wr_pend_reg && sel_ok && in_y |=> shy_reg[$past(sel_p)][$past(y_off)] == $past(wdat)) // RULE_13
    else $error("y shadow byte not stored");

  // ----------------------------------------------------------------
  // gpio configuration and transfer pin
  // ----------------------------------------------------------------
  // per-pin function select
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int k = 0; k < NUM_GPIO; k++)
        gpio_cfg_reg[k] <= fir_coef_pkg::REG_RESET;
    end
    else if (wr_pend_reg && idx_reg >= fir_coef_pkg::IDX_GPIO_LO
             && idx_reg < fir_coef_pkg::IDX_GPIO_LO + 14'(NUM_GPIO))
      gpio_cfg_reg[idx_reg[1:0]] <= wdat; // RULE_18
  end

  // two-stage synchroniser plus edge history
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gmeta_reg <= '0;
      gsync_reg <= '0;
      gprev_reg <= '0;
    end
    else
    begin
      gmeta_reg <= gpio_in;
      gsync_reg <= gmeta_reg;
      gprev_reg <= gsync_reg;
    end
  end

  // rising edge on any pin carrying the transfer function
  always_comb
  begin
    gpio_hit = 1'b0;
    for (int k = 0; k < NUM_GPIO; k++)
      if (gsync_reg[k] && !gprev_reg[k] && gpio_cfg_reg[k][3:0] == fir_coef_pkg::GPIO_FN_XFER)
        gpio_hit = 1'b1; // RULE_19
  end

  sequence pin1_rise_s;
    !gsync_reg[1] ##1 gsync_reg[1];
  endsequence
  gpio_xfer_a: assert property (pin1_rise_s ##0 gpio_cfg_reg[1][3:0] == 4'h1 |=> coef_apply_pulse) // RULE_19
    else $error("gpio rising edge did not apply coefficients");
  gpio_quiet_a: assert property (gpio_cfg_reg[0][3:0] != 4'h1 && gpio_cfg_reg[1][3:0] != 4'h1 // RULE_18
    && gpio_cfg_reg[2][3:0] != 4'h1 && !(wr_pend_reg && idx_reg == 14'h000f) |=> !coef_apply_pulse)
    else $error("transfer without a configured source");

  // ----------------------------------------------------------------
  // transfer: shadow to applied coefficients
  // ----------------------------------------------------------------
  assign xfer_go = (wr_pend_reg && idx_reg == fir_coef_pkg::IDX_XFER && wdat == fir_coef_pkg::XFER_CMD) // RULE_17
                   || gpio_hit;

  // applied sets move only on a transfer; bytes pair low then high
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int p = 0; p < 2; p++)
        for (int t = 0; t < fir_coef_pkg::COEF_TAPS; t++)
        begin
          actx_reg[p][t] <= 16'h0000;
          acty_reg[p][t] <= 16'h0000;
        end
      dly_act_reg <= 6'h00;
    end
    else if (xfer_go) // RULE_16 RULE_23
    begin
      for (int p = 0; p < 2; p++)
        for (int t = 0; t < fir_coef_pkg::COEF_TAPS; t++)
        begin
          actx_reg[p][t] <= {shx_reg[p][2*t+1], shx_reg[p][2*t]}; // RULE_12 RULE_21
          acty_reg[p][t] <= {shy_reg[p][2*t+1], shy_reg[p][2*t]}; // RULE_13 RULE_21
        end
      dly_act_reg <= dly_sh_reg; // RULE_22
    end
  end

  // transfer pulse and counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      coef_apply_reg <= 1'b0;
      xfer_cnt_reg <= 8'h00;
    end
    else
    begin
      coef_apply_reg <= xfer_go;
      if (xfer_go)
        xfer_cnt_reg <= xfer_cnt_reg + 8'h01;
    end
  end

  assign coef_apply_pulse = coef_apply_reg;
  assign tap_delay_i = dly_act_reg;

  // flatten applied sets; each tap is a signed Q1.15 word
  for (genvar t = 0; t < fir_coef_pkg::COEF_TAPS; t++)
  begin : g_flat
    assign inphase_x_coef_set[16*t +: 16] = actx_reg[0][t]; // RULE_21
    assign inphase_y_coef_set[16*t +: 16] = acty_reg[0][t];
    assign quadrature_x_coef_set[16*t +: 16] = actx_reg[1][t];
    assign quadrature_y_coef_set[16*t +: 16] = acty_reg[1][t];
  end

  strobe_apply_a: assert property (wr_pend_reg && idx_reg == 14'h000f && hwdata[7:0] == 8'h01 // RULE_17
    |=> coef_apply_pulse && xfer_cnt_reg == $past(xfer_cnt_reg) + 8'h01)
    else $error("apply strobe write did not transfer");
  coef_apply_a: assert property (xfer_go |=> actx_reg[1][23] == {$past(shx_reg[1][47]), $past(shx_reg[1][46])} // RULE_16
    && acty_reg[0][0] == {$past(shy_reg[0][1]), $past(shy_reg[0][0])})
    else $error("shadow not applied on transfer");
  coef_hold_a: assert property (!xfer_go |=> $stable(actx_reg[0][0]) && $stable(acty_reg[1][23]) // RULE_23
    && $stable(tap_delay_i))
    else $error("applied coefficients changed without transfer");
  delay_range_a: assert property (tap_delay_i <= 6'd47) // RULE_22
    else $error("tapped delay above 47");

endmodule
